// [pkg/spi_link_pkg.sv]
/*
 Shared constants, types and the frame check function for the serial control link.
 Assumes a 25 MHz system clock on both ends of the link.
*/
`default_nettype none
package spi_link_pkg;

   // Frame layout
   localparam int FRAME_BITS = 32;
   localparam logic [5:0] FRAME_FALLS = 6'h20;
   localparam int SLIP_BIT = 31;
   localparam int DEV_ADDR_HI = 30;
   localparam int DEV_ADDR_LO = 29;
   localparam int REG_ADDR_HI = 28;
   localparam int REG_ADDR_LO = 24;
   localparam int DATA_HI = 23;
   localparam int DATA_LO = 8;
   localparam int ALARM_STAT_BIT = 29;
   localparam logic [1:0] READ_SYNC = 2'h2;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;
   localparam logic [7:0] CRC_BLANK = 8'h00;

   // Register addresses
   localparam logic [4:0] REG_NOP = 5'h00;
   localparam logic [4:0] REG_DATA = 5'h01;
   localparam logic [4:0] REG_RB_SELECT = 5'h02;
   localparam logic [4:0] REG_CONFIG = 5'h03;
   localparam logic [4:0] REG_DIAG_FLAGS = 5'h04;
   localparam logic [4:0] REG_STATUS = 5'h05;

   // Config fields
   localparam int CFG_CRC_EN = 0;
   localparam int CFG_MODE_LO = 1;
   localparam int CFG_MODE_HI = 2;
   localparam int CFG_ALARM_ON_CRC = 3;

   // Diagnostic flag and status positions
   localparam int FLAG_CRC = 0;
   localparam int FLAG_SLIP = 1;
   localparam int FLAG_COUNT = 2;
   localparam int STAT_SUMMARY = 0;
   localparam int STAT_ALARM = 1;

   // Reset values
   localparam logic RST_CRC_EN = 1'h1;
   localparam logic RST_ALARM_ON_CRC = 1'h1;
   localparam logic [15:0] RST_DATA = 16'h0000;
   localparam logic [4:0] RST_RB_SELECT = 5'h00;

   // Timing
   localparam int CLOCK_PERIOD_NS = 40;
   localparam int RESET_QUIET_US = 100;
   localparam int RESET_QUIET_CYCLES = (RESET_QUIET_US * 1000 + CLOCK_PERIOD_NS - 1)
      / CLOCK_PERIOD_NS;
   localparam logic [3:0] SCLK_HALF_CYCLES = 4'h8;

   typedef enum logic [1:0] {
      RB_TWO_STAGE,
      RB_AUTO_STATUS,
      RB_SHARED_STATUS,
      RB_ECHO
   } rb_mode_type;

   function automatic logic [7:0] crc8_of(input logic [23:0] bits);
      logic [7:0] c;
      logic fb;
      c = CRC_INIT;
      for (int i = 23; i >= 0; i--) begin
         fb = c[7] ^ bits[i];
         c = {c[6:0], 1'b0};
         if (fb) begin
            c = c ^ CRC_POLY;
         end
      end
      return c;
   endfunction : crc8_of

endpackage : spi_link_pkg
`default_nettype wire

// [pkg/spi_link_if.sv]
/*
 Four-wire serial link plus open-drain alarm between controller and device.
 Undriven data out and alarm lines are pulled high here.
*/
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
   logic sclk;
   logic syncB;
   logic sdi;
   logic sdo;
   logic sdoOe;
   logic alarmOut;
   logic alarmOe;
   logic sdoLine;
   logic alarmB;

   assign sdoLine = sdoOe ? sdo : 1'b1;
   assign alarmB = alarmOe ? alarmOut : 1'b1;

   modport device (input sclk, input syncB, input sdi, output sdo, output sdoOe,
      output alarmOut, output alarmOe);
   modport host (output sclk, output syncB, output sdi, input sdoLine, input alarmB);
endinterface : spi_link_if
`default_nettype wire

// [rtl/pin_sync.sv]
/*
 Three-stage input synchroniser with agreement filter, one bit per lane.
 Assumes inputs are asynchronous to clock; output moves once stages two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // System
   input wire logic clock,
   input wire logic rst_b,
   // Pins
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] level
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } sync_state_type;

   sync_state_type r;
   sync_state_type next_r;

   always_comb begin
      next_r = r;
      next_r.s1 = pinIn;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            next_r.lvl[i] = r.s3[i];
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         r <= {INIT, INIT, INIT, INIT};
      end else begin
         r <= next_r;
      end
   end

   assign level = r.lvl;
endmodule : pin_sync
`default_nettype wire

// [rtl/spi_ctrl_device.sv]
/*
 Device end of the serial control port: frame capture, checks, registers, readback.
 Assumes the link pins are asynchronous and slower than clock (half period of 4 cycles or more).
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1 - Shift 32-bit frames in, MSB first
// RULE2 - Sample input data on serial clock fall
// RULE3 - CRC off: use 24 bits, drop last 8
// RULE4 - Frame: slip, device addr, reg addr, data, check
// RULE5 - Accept only when address bits match pins
// RULE6 - Check byte is CRC-8, poly x8+x2+x+1
// RULE7 - Controller sends 32 bits before raising select
// RULE8 - CRC on after reset; exactly 32 bits
// RULE9 - Bad check: discard, alarm low, flag error
// RULE10 - Flags clear by writing one; CRC bit 0
// RULE11 - Config bit decides if CRC drives alarm
// RULE12 - Returned frames also carry a check byte
// RULE13 - Top bit must invert next; else slip error
// RULE14 - Only 32 falling edges accepted; else flag
// RULE15 - Four readback modes selectable
// RULE16 - Two-stage read: select, then no-op frame
// RULE17 - Readback: 0b10, alarm, address, data, check
// RULE18 - Auto status every frame; off after reset
// RULE19 - Echo mode: alternate frames echo last write
// RULE20 - Controller waits 100 us after reset
// RULE21 - Failed frames leave registers unchanged
module spi_ctrl_device
   import spi_link_pkg::*;
(
   // System
   input wire logic clock,
   input wire logic rst_b,
   // Link
   spi_link_if.device link,
   // Address straps
   input wire logic devAddrPinLo,
   input wire logic devAddrPinHi,
   // User side
   output logic [15:0] dacData,
   output logic writeStrobe
);
   typedef struct packed {
      logic sclkPrev;
      logic selPrev;
      logic active;
      logic [5:0] falls;
      logic [31:0] rx;
      logic [31:0] tx;
      logic sdoOe;
      logic [15:0] dacData;
      logic writeStrobe;
      logic [4:0] rbSel;
      logic crcEn;
      rb_mode_type rbMode;
      logic alarmOnCrc;
      logic [2:0] flags;
      logic echoPhase;
      logic [4:0] lastAddr;
      logic [15:0] lastData;
      logic chosen;
      logic alarmOe;
   } dev_state_type;

   dev_state_type r;
   dev_state_type next_r;
   logic [4:0] pins;

   // Straps pass the same filter; they are sampled only when a frame ends
   pin_sync #(
      .WIDTH(5),
      .INIT(5'h03)
   ) u_sync (
      .clock(clock),
      .rst_b(rst_b),
      .pinIn({devAddrPinHi, devAddrPinLo, link.sdi, link.syncB, link.sclk}),
      .level(pins)
   );

   logic sclkL;
   logic selL;
   logic sdiL;
   logic [1:0] strapL;
   logic fall;
   logic rise;
   logic [15:0] statWord;
   logic [4:0] rdAddr;
   logic [15:0] rdData;
   logic [23:0] head;
   logic countOk;
   logic slipOk;
   logic addrOk;
   logic crcOk;
   logic frameOk;
   logic [2:0] setFlags;
   logic [2:0] clrFlags;
   logic [4:0] wAddr;
   logic [15:0] wData;
   logic [2:0] alarmMask;

   assign sclkL = pins[0];
   assign selL = pins[1];
   assign sdiL = pins[2];
   assign strapL = pins[4:3];

   always_comb begin
      next_r = r;
      next_r.writeStrobe = 1'b0;
      fall = r.sclkPrev & ~sclkL;
      rise = ~r.sclkPrev & sclkL;
      next_r.sclkPrev = sclkL;
      next_r.selPrev = selL;

      statWord = 16'h0000;
      statWord[STAT_SUMMARY] = |r.flags;
      statWord[STAT_ALARM] = r.alarmOe;

      // Readback source chosen by mode
      rdAddr = REG_STATUS; // RULE18
      unique case (r.rbMode) // RULE15
         RB_TWO_STAGE: rdAddr = r.rbSel; // RULE16
         RB_AUTO_STATUS: rdAddr = REG_STATUS;
         RB_SHARED_STATUS: rdAddr = REG_STATUS;
         RB_ECHO: rdAddr = r.echoPhase ? r.lastAddr : REG_STATUS; // RULE19
      endcase
      unique case (rdAddr)
         REG_DATA: rdData = r.dacData;
         REG_RB_SELECT: rdData = {11'h000, r.rbSel};
         REG_CONFIG: rdData = {12'h000, r.alarmOnCrc, r.rbMode, r.crcEn};
         REG_DIAG_FLAGS: rdData = {13'h0000, r.flags};
         REG_STATUS: rdData = statWord;
         default: rdData = 16'h0000;
      endcase
      if (r.rbMode == RB_ECHO && r.echoPhase) begin
         rdData = r.lastData; // RULE19
      end
      head = {READ_SYNC, r.alarmOe, rdAddr, rdData}; // RULE17

      countOk = (r.falls == FRAME_FALLS); // RULE14
      slipOk = r.rx[SLIP_BIT] != r.rx[DEV_ADDR_HI]; // RULE13
      addrOk = r.rx[DEV_ADDR_HI:DEV_ADDR_LO] == strapL; // RULE5
      // With the check off, the trailing byte is simply not looked at
      crcOk = ~r.crcEn | (crc8_of(r.rx[31:8]) == r.rx[7:0]); // RULE3 RULE6 RULE8
      frameOk = countOk & slipOk & crcOk;
      wAddr = r.rx[REG_ADDR_HI:REG_ADDR_LO]; // RULE4
      wData = r.rx[DATA_HI:DATA_LO];
      setFlags = 3'h0;
      clrFlags = 3'h0;

      if (r.selPrev & ~selL) begin
         // Frame start: first readback bit goes out before the first edge
         next_r.active = 1'b1;
         next_r.falls = 6'h00;
         next_r.tx = {head, crc8_of(head)}; // RULE12
         // Shared select: only the device picked by the last frame drives out
         next_r.sdoOe = (r.rbMode == RB_SHARED_STATUS) ? r.chosen : 1'b1;
         if (r.rbMode == RB_ECHO) begin
            next_r.echoPhase = ~r.echoPhase;
         end
      end else if (r.active & ~selL) begin
         if (fall) begin
            next_r.rx = {r.rx[30:0], sdiL}; // RULE1 RULE2
            if (r.falls != 6'h3F) begin
               next_r.falls = 6'(r.falls + 6'h01);
            end
         end
         if (rise && r.falls != 6'h00) begin
            next_r.tx = {r.tx[30:0], 1'b0};
         end
      end else if (r.active & selL) begin
         // Frame end: evaluate once select goes high
         next_r.active = 1'b0; // RULE7
         next_r.sdoOe = 1'b0;
         next_r.chosen = addrOk & countOk;
         setFlags[FLAG_COUNT] = ~countOk; // RULE14
         setFlags[FLAG_SLIP] = countOk & ~slipOk; // RULE13
         setFlags[FLAG_CRC] = countOk & slipOk & ~crcOk; // RULE9
         if (frameOk & addrOk) begin // RULE21
            next_r.lastAddr = wAddr;
            next_r.lastData = wData;
            unique case (wAddr)
               REG_DATA: begin
                  next_r.dacData = wData;
                  next_r.writeStrobe = 1'b1;
               end
               REG_RB_SELECT: next_r.rbSel = wData[4:0]; // RULE16
               REG_CONFIG: begin
                  next_r.crcEn = wData[CFG_CRC_EN];
                  next_r.rbMode = rb_mode_type'(wData[CFG_MODE_HI:CFG_MODE_LO]);
                  next_r.alarmOnCrc = wData[CFG_ALARM_ON_CRC]; // RULE11
                  next_r.echoPhase = 1'b0;
               end
               REG_DIAG_FLAGS: clrFlags = wData[2:0]; // RULE10
               default: ;
            endcase
         end
      end

      // A new error wins over a clear in the same frame
      next_r.flags = (r.flags & ~clrFlags) | setFlags; // RULE10
      alarmMask = 3'h7;
      alarmMask[FLAG_CRC] = next_r.alarmOnCrc; // RULE11
      next_r.alarmOe = |(next_r.flags & alarmMask); // RULE9
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
         r.sclkPrev <= 1'b1;
         r.selPrev <= 1'b1;
         r.dacData <= RST_DATA;
         r.rbSel <= RST_RB_SELECT;
         r.crcEn <= RST_CRC_EN; // RULE8
         r.rbMode <= RB_TWO_STAGE; // RULE18
         r.alarmOnCrc <= RST_ALARM_ON_CRC;
      end else begin
         r <= next_r;
      end
   end

   assign link.sdo = r.tx[FRAME_BITS-1];
   assign link.sdoOe = r.sdoOe;
   // Open drain: only ever pulls low
   assign link.alarmOut = 1'b0;
   assign link.alarmOe = r.alarmOe;
   assign dacData = r.dacData;
   assign writeStrobe = r.writeStrobe;
endmodule : spi_ctrl_device
`default_nettype wire

// [rtl/spi_ctrl_host.sv]
/*
 Controller end of the serial control port: builds and shifts frames, checks readback.
 Assumes clock at 25 MHz; serial clock is made here by a divider and idles high.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_ctrl_host
   import spi_link_pkg::*;
(
   // System
   input wire logic clock,
   input wire logic rst_b,
   // Link
   spi_link_if.host link,
   // Command
   input wire logic cmdValid,
   input wire logic [1:0] cmdDevAddr,
   input wire logic [4:0] cmdRegAddr,
   input wire logic [15:0] cmdData,
   input wire logic cmdCrcOn,
   output logic cmdReady,
   // Response
   output logic rspValid,
   output logic [31:0] rspWord,
   output logic rspCrcOk,
   output logic alarmSeen
);
   typedef enum logic [2:0] {QUIET, IDLE, LEAD, LOW, HIGH, TAIL, GAP} host_state_type;

   typedef struct packed {
      host_state_type state;
      logic [11:0] timer;
      logic [5:0] bits;
      logic [31:0] txSh;
      logic [31:0] rxSh;
      logic sclk;
      logic syncB;
      logic sdi;
      logic ready;
      logic rspValid;
      logic [31:0] rspWord;
      logic rspCrcOk;
      logic alarmSeen;
   } host_state_r_type;

   host_state_r_type r;
   host_state_r_type next_r;
   logic [1:0] pins;
   logic [23:0] head;
   logic halfDone;

   pin_sync #(
      .WIDTH(2),
      .INIT(2'h3)
   ) u_sync (
      .clock(clock),
      .rst_b(rst_b),
      .pinIn({link.alarmB, link.sdoLine}),
      .level(pins)
   );

   always_comb begin
      next_r = r;
      next_r.rspValid = 1'b0;
      next_r.alarmSeen = ~pins[1];
      halfDone = r.timer == 12'(SCLK_HALF_CYCLES - 4'h1);
      next_r.timer = halfDone ? 12'h000 : 12'(r.timer + 12'h001);
      // Slip bit is the inverse of the next bit
      head = {~cmdDevAddr[1], cmdDevAddr, cmdRegAddr, cmdData}; // RULE4
      unique case (r.state)
         QUIET: begin
            next_r.timer = 12'(r.timer + 12'h001);
            if (r.timer == 12'(RESET_QUIET_CYCLES - 1)) begin // RULE20
               next_r.state = IDLE;
               next_r.ready = 1'b1;
            end
         end
         IDLE: begin
            next_r.timer = 12'h000;
            if (cmdValid) begin
               next_r.txSh = {head, cmdCrcOn ? crc8_of(head) : CRC_BLANK}; // RULE6 RULE8
               next_r.sdi = head[23]; // RULE1
               next_r.syncB = 1'b0;
               next_r.ready = 1'b0;
               next_r.bits = 6'h00;
               next_r.state = LEAD;
            end
         end
         LEAD, HIGH: begin
            if (halfDone) begin
               next_r.sclk = 1'b0;
               next_r.state = LOW;
            end
         end
         LOW: begin
            if (halfDone) begin
               // Sample just before the rise; the device moves its output after it
               next_r.rxSh = {r.rxSh[30:0], pins[0]};
               next_r.sclk = 1'b1;
               next_r.bits = 6'(r.bits + 6'h01);
               next_r.txSh = {r.txSh[30:0], 1'b0};
               next_r.sdi = r.txSh[30];
               next_r.state = (r.bits == FRAME_FALLS - 6'h01) ? TAIL : HIGH; // RULE7
            end
         end
         TAIL: begin
            if (halfDone) begin
               next_r.syncB = 1'b1; // RULE7
               next_r.rspValid = 1'b1;
               next_r.rspWord = r.rxSh;
               next_r.rspCrcOk = crc8_of(r.rxSh[31:8]) == r.rxSh[7:0]; // RULE12
               next_r.state = GAP;
            end
         end
         GAP: begin
            if (halfDone) begin
               next_r.ready = 1'b1;
               next_r.state = IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
         r.state <= QUIET;
         r.sclk <= 1'b1;
         r.syncB <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign link.sclk = r.sclk;
   assign link.syncB = r.syncB;
   assign link.sdi = r.sdi;
   assign cmdReady = r.ready;
   assign rspValid = r.rspValid;
   assign rspWord = r.rspWord;
   assign rspCrcOk = r.rspCrcOk;
   assign alarmSeen = r.alarmSeen;
endmodule : spi_ctrl_host
`default_nettype wire

// [sim/spi_frame_checker_readback_sva.sv]
/*
 Link checker: timing and framing of the wire between host and device.
 Assumes it sits beside the link that joins the two design ends.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_frame_checker_readback_sva
   import spi_link_pkg::*;
(
   // System
   input wire logic clock,
   input wire logic rst_b,
   // Link
   input wire logic sclk,
   input wire logic syncB,
   input wire logic sdi,
   input wire logic sdoOe,
   input wire logic alarmOut,
   input wire logic alarmOe
);
   logic [5:0] falls;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Falls seen in the current frame
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         falls <= 6'h00;
      end else if (syncB) begin
         falls <= 6'h00;
      end else if ($fell(sclk)) begin
         falls <= falls + 6'h01;
      end
   end
   a_alarm_open_drain: assert property (alarmOe |-> !alarmOut)
      else $error("alarm line driven high");
   a_sclk_idle_high: assert property (syncB |-> sclk)
      else $error("serial clock low outside frame");
   a_lead_before_fall: assert property ($fell(syncB) |-> sclk [*8] ##1 !sclk)
      else $error("bad lead before first fall");
   a_sclk_low_span: assert property ($fell(sclk) |-> (!sclk) [*8] ##1 sclk)
      else $error("bad serial clock low time");
   a_sdi_hold_low: assert property (!sclk && !$past(sclk) |-> $stable(sdi))
      else $error("data moved while clock low");
   a_frame_falls_32: assert property ($rose(syncB) |-> falls == FRAME_FALLS)
      else $error("frame closed with wrong fall count");
   a_alarm_after_frame: assert property ($changed(alarmOe) |-> syncB)
      else $error("alarm moved inside a frame");
   a_sdo_quiet_idle: assert property (syncB [*8] |-> !sdoOe)
      else $error("data out driven between frames");
endmodule : spi_frame_checker_readback_sva
`default_nettype wire

// [sim/spi_frame_checker_readback_tb.sv]
/*
 Testbench: host and device joined by one link, a second device bit-banged.
 Assumes the design package, link interface and both ends are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_frame_checker_readback_tb
   import spi_link_pkg::*;
;
   localparam logic [1:0] DEV = 2'h2;
   logic clock, rst_b, cmdValid, cmdCrcOn, cmdReady, rspValid, rspCrcOk, alarmSeen;
   logic writeStrobe, pinLo, pinHi;
   logic [1:0] cmdDevAddr;
   logic [4:0] cmdRegAddr;
   logic [15:0] cmdData, dacData, dacDataB;
   logic [31:0] rspWord, rsp;
   int badCount = 0;
   int nChecks = 0;
   int strobes = 0;
   spi_link_if la();
   spi_link_if lb();
   spi_ctrl_host u_spi_ctrl_host (.clock(clock), .rst_b(rst_b), .link(la.host),
      .cmdValid(cmdValid), .cmdDevAddr(cmdDevAddr), .cmdRegAddr(cmdRegAddr),
      .cmdData(cmdData), .cmdCrcOn(cmdCrcOn), .cmdReady(cmdReady), .rspValid(rspValid),
      .rspWord(rspWord), .rspCrcOk(rspCrcOk), .alarmSeen(alarmSeen));
   spi_ctrl_device u_spi_ctrl_device (.clock(clock), .rst_b(rst_b), .link(la.device),
      .devAddrPinLo(pinLo), .devAddrPinHi(pinHi), .dacData(dacData),
      .writeStrobe(writeStrobe));
   // Second device faces the bench driver, which breaks the framing on purpose
   spi_ctrl_device u_spi_ctrl_device_b (.clock(clock), .rst_b(rst_b), .link(lb.device),
      .devAddrPinLo(pinLo), .devAddrPinHi(pinHi), .dacData(dacDataB), .writeStrobe());
   spi_frame_checker_readback_sva u_spi_frame_checker_readback_sva (.clock(clock),
      .rst_b(rst_b), .sclk(la.sclk), .syncB(la.syncB), .sdi(la.sdi), .sdoOe(la.sdoOe),
      .alarmOut(la.alarmOut), .alarmOe(la.alarmOe));
   always #20 clock = ~clock;
   always @(posedge clock) begin
      if (writeStrobe === 1'b1) begin
         strobes++;
      end
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      nChecks++;
      if (s !== e) begin
         badCount++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   function automatic logic [7:0] crc(input logic [23:0] b);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CRC_POLY : 8'h00);
      end
      return c;
   endfunction : crc
   function automatic logic [31:0] fr(input logic [1:0] d, input logic [4:0] r,
         input logic [15:0] v);
      return {~d[1], d, r, v, crc({~d[1], d, r, v})};
   endfunction : fr
   function automatic logic [31:0] rb(input logic a, input logic [4:0] r,
         input logic [15:0] v);
      return {READ_SYNC, a, r, v, crc({READ_SYNC, a, r, v})};
   endfunction : rb
   // One host command; returns settled, 12 cycles after the response
   task automatic cmd(input logic [1:0] d, input logic [4:0] r, input logic [15:0] v,
         input logic c);
      int n;
      n = 0;
      while (cmdReady !== 1'b1 && n < 3000) begin
         @(posedge clock);
         #1 n++;
      end
      @(posedge clock);
      cmdValid <= 1'b1;
      {cmdDevAddr, cmdRegAddr, cmdData, cmdCrcOn} <= {d, r, v, c};
      @(posedge clock);
      cmdValid <= 1'b0;
      n = 0;
      while (rspValid !== 1'b1 && n < 700) begin
         @(posedge clock);
         #1 n++;
      end
      rsp = rspWord;
      chk("rspValid", n < 700, 1);
      repeat (12) @(posedge clock);
      #1;
   endtask : cmd
   task automatic rd(input logic [4:0] r);
      cmd(DEV, REG_RB_SELECT, {11'h000, r}, 1'b1);
      cmd(DEV, REG_NOP, 16'h0000, 1'b1);
   endtask : rd
   // Bench-made frame on the second link, 320 ns serial clock; sdo taken just before each rise
   task automatic bang(input logic [31:0] w, input int n);
      rsp = 32'h0000_0000;
      @(posedge clock);
      lb.syncB <= 1'b0;
      lb.sdi <= w[31];
      repeat (n) begin
         repeat (4) @(posedge clock);
         lb.sclk <= 1'b0;
         repeat (3) @(posedge clock);
         #1 rsp = {rsp[30:0], lb.sdoLine};
         @(posedge clock);
         lb.sclk <= 1'b1;
         w = w << 1;
         lb.sdi <= w[31];
      end
      repeat (4) @(posedge clock);
      lb.syncB <= 1'b1;
      repeat (25) @(posedge clock);
      #1;
   endtask : bang
   task automatic t_quiet();
      int n;
      n = 0;
      while (cmdReady !== 1'b1 && n < 3000) begin
         @(posedge clock);
         #1 n++;
      end
      chk("quietCycles", n, RESET_QUIET_CYCLES);
   endtask : t_quiet
   task automatic t_write_read();
      int s;
      s = strobes;
      cmd(DEV, REG_DATA, 16'hA5C3, 1'b1);
      chk("dacData", dacData, 16'hA5C3);
      chk("strobes", strobes - s, 1);
      cmd(2'h1, REG_DATA, 16'h5A5A, 1'b1);
      chk("dacData", dacData, 16'hA5C3);
      rd(REG_DATA);
      chk("readback", rsp, rb(1'b0, REG_DATA, 16'hA5C3));
      chk("rspCrcOk", rspCrcOk, 1'b1);
   endtask : t_write_read
   task automatic t_bad_crc();
      cmd(DEV, REG_DATA, 16'h1234, 1'b0);
      chk("dacData", dacData, 16'hA5C3);
      chk("alarmSeen", alarmSeen, 1'b1);
      rd(REG_DIAG_FLAGS);
      chk("flags", rsp, rb(1'b1, REG_DIAG_FLAGS, 16'h0001));
      rd(REG_STATUS);
      chk("status", rsp, rb(1'b1, REG_STATUS, 16'h0003));
      cmd(DEV, REG_DIAG_FLAGS, 16'h0001, 1'b1);
      chk("alarmSeen", alarmSeen, 1'b0);
   endtask : t_bad_crc
   task automatic t_crc_config();
      cmd(DEV, REG_CONFIG, 16'h0008, 1'b1);
      cmd(DEV, REG_DATA, 16'h0F0F, 1'b0);
      chk("dacData", dacData, 16'h0F0F);
      cmd(DEV, REG_CONFIG, 16'h0001, 1'b1);
      cmd(DEV, REG_DATA, 16'h1111, 1'b0);
      chk("alarmSeen", alarmSeen, 1'b0);
      chk("dacData", dacData, 16'h0F0F);
      cmd(DEV, REG_CONFIG, 16'h0009, 1'b1);
      chk("alarmSeen", alarmSeen, 1'b1);
      cmd(DEV, REG_DIAG_FLAGS, 16'h0001, 1'b1);
   endtask : t_crc_config
   task automatic t_modes();
      cmd(DEV, REG_CONFIG, 16'h000B, 1'b1);
      cmd(DEV, REG_NOP, 16'h0000, 1'b1);
      chk("autoStatus", rsp, rb(1'b0, REG_STATUS, 16'h0000));
      cmd(DEV, REG_CONFIG, 16'h000F, 1'b1);
      cmd(DEV, REG_RB_SELECT, 16'h0004, 1'b1);
      chk("echoStatus", rsp, rb(1'b0, REG_STATUS, 16'h0000));
      cmd(DEV, REG_NOP, 16'h0000, 1'b1);
      chk("echo", rsp, rb(1'b0, REG_RB_SELECT, 16'h0004));
      cmd(DEV, REG_CONFIG, 16'h000D, 1'b1);
      cmd(2'h1, REG_NOP, 16'h0000, 1'b1);
      cmd(DEV, REG_NOP, 16'h0000, 1'b1);
      chk("shared", rsp, 32'hFFFF_FFFF);
      cmd(DEV, REG_NOP, 16'h0000, 1'b1);
      chk("shared", rsp, rb(1'b0, REG_STATUS, 16'h0000));
      cmd(DEV, REG_CONFIG, 16'h0009, 1'b1);
   endtask : t_modes
   task automatic t_faults();
      logic [31:0] w;
      w = fr(DEV, REG_DATA, 16'h7777);
      bang({~w[31], w[30:0]}, 32);
      chk("dacDataB", dacDataB, 16'h0000);
      chk("alarmB", lb.alarmB, 1'b0);
      bang(w, 24);
      bang(w, 31);
      chk("dacDataB", dacDataB, 16'h0000);
      bang(fr(DEV, REG_RB_SELECT, {11'h000, REG_DIAG_FLAGS}), 32);
      bang(fr(DEV, REG_NOP, 16'h0000), 32);
      chk("flagsB", rsp, rb(1'b1, REG_DIAG_FLAGS, 16'h0006));
      bang(w, 32);
      chk("dacDataB", dacDataB, 16'h7777);
   endtask : t_faults
   task automatic final_report();
      if (badCount == 0 && nChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report
   initial begin
      clock = 1'b0;
      rst_b = 1'b0;
      {cmdValid, cmdCrcOn, cmdDevAddr, cmdRegAddr, cmdData} <= '0;
      {pinHi, pinLo} <= DEV;
      lb.sclk <= 1'b1;
      lb.syncB <= 1'b1;
      lb.sdi <= 1'b0;
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      t_quiet();
      t_write_read();
      t_bad_crc();
      t_crc_config();
      t_modes();
      t_faults();
      final_report();
   end
   // Cuts a hang; the full run needs roughly 0.7 ms
   initial begin
      #3000000;
      badCount++;
      final_report();
   end
endmodule : spi_frame_checker_readback_tb
`default_nettype wire
